/* hdl/imscu_defines.vh */
// Register offsets, field layouts, reset values for the mask unit
`ifndef IMSCU_DEFINES_VH
`define IMSCU_DEFINES_VH

`define IMSCU_ADDR_W 4
`define IMSCU_OFF_MASK_LOW 4'h0
`define IMSCU_OFF_MASK_HIGH 4'h1
`define IMSCU_OFF_CLR_LOW 4'h2
`define IMSCU_OFF_CLR_HIGH 4'h3
`define IMSCU_OFF_SET_LOW 4'h4
`define IMSCU_OFF_SET_HIGH 4'h5
`define IMSCU_OFF_SAVE0 4'h6
`define IMSCU_OFF_SAVE1 4'h7
`define IMSCU_OFF_SAVE2 4'h8
`define IMSCU_OFF_SAVE3 4'h9
`define IMSCU_OFF_TIMER_PL 4'hA

// Implemented mask bits per word
`define IMSCU_LOW_VALID 32'hFFCC_0782
`define IMSCU_HIGH_VALID 32'h0001_803F
`define IMSCU_LOW_RESET 32'hFFFC_0782
`define IMSCU_HIGH_RESET 32'h0001_803F
// Reserved low bits 21:20 read one but are not writable
`define IMSCU_LOW_FIXED1 32'h0030_0000

`define IMSCU_PL_W 2
`define IMSCU_PL_RESET 2'h0

// Low-word source positions
`define IMSCU_B_MEM_FAULT 1
`define IMSCU_B_IO_NET_REFILL 7
`define IMSCU_B_USER_NET_REFILL 8
`define IMSCU_B_IO_NET_DONE 9
`define IMSCU_B_USER_NET_DONE 10
`define IMSCU_B_DMA_XLATE_MISS 18
`define IMSCU_B_DMA_XLATE_VIOL 19
`define IMSCU_B_STATIC_NET_GUARD 22
`define IMSCU_B_IO_NET_GUARD 23
`define IMSCU_B_USER_NET_GUARD 24
`define IMSCU_B_CORE_TIMER 25
`define IMSCU_B_IO_NET_TIMEOUT 26
`define IMSCU_B_USER_NET_TIMEOUT 27
`define IMSCU_B_DMA_NOTICE 28
`define IMSCU_B_IO_NET_CAVAIL 29
`define IMSCU_B_USER_NET_CAVAIL 30
`define IMSCU_B_IO_NET_DATA_AVAIL 31
// High-word source positions
`define IMSCU_B_USER_NET_DATA_AVAIL 0
`define IMSCU_B_PERF_OVERFLOW 1
`define IMSCU_B_SOFT_INT_LEVEL3 2
`define IMSCU_B_SOFT_INT_LEVEL0 5
`define IMSCU_B_STATIC_NET_PORT_VIOL 15
`define IMSCU_B_AUX_PERF_OVERFLOW 16

`endif

/* hdl/imscu_mask_word.v */
// One 32-bit mask word with set and clear strobes
`timescale 1ns/1ps
module imscu_mask_word #(
	parameter [31:0] VALID = 32'hFFFF_FFFF,
	parameter [31:0] RESET_VAL = 32'hFFFF_FFFF
) (
	input wire i_mclk,
	input wire i_reset,
	input wire i_set_stb,
	input wire i_clr_stb,
	input wire [31:0] i_wdata,
	output reg [31:0] o_mask
);
	wire [31:0] set_bits;
	wire [31:0] clr_bits;
	reg [31:0] mask_next;

	// Reserved positions ignore writes
	assign set_bits = i_set_stb ? (i_wdata & VALID) : 32'h0000_0000; // see [R21]
	assign clr_bits = i_clr_stb ? (i_wdata & VALID) : 32'h0000_0000; // see [R21]

	always @* begin
		// Set wins over clear on the same bit
		mask_next = (o_mask & ~clr_bits) | set_bits; // see [R1] see [R2] see [R20]
	end

	always @(posedge i_mclk) begin
		if (i_reset) begin
			o_mask <= RESET_VAL; // see [R19]
		end else begin
			o_mask <= mask_next;
		end
	end
endmodule // imscu_mask_word

/* hdl/imscu_top.v */
// Interrupt mask set/clear unit with save and timer privilege registers
// Summary of operation
// [R1] High clear word clears mask bits for interrupts 32-37 where one written.
// [R2] Set words set mask bits written one; low set covers 0-31.
// [R3] High set word acts on interrupts 32-37 via low bit positions.
// [R4] Clear-low bit 19 enables DMA xlate violation, bit 18 xlate miss.
// [R5] Low bits 31,30,29: io data avail, user cavail, io cavail.
// [R6] Low bits 28,27,26: DMA notice, user timeout, io timeout.
// [R7] Low bit 25 core timer, bit 24 user network guard.
// [R8] Low bit 23 io guard, 22 static guard; 21:20 reserved.
// [R9] Low bits 10,9 done; 8,7 refill; 17:11 reserved.
// [R10] Low bit 1 memory fault; 6:2 and 0 reserved.
// [R11] High bit 16 aux perf overflow, 15 static port violation.
// [R12] High bits 5,4,3,2 soft interrupts for levels 0,1,2,3.
// [R13] High bit 1 performance counter overflow.
// [R14] High bit 0 user network data available.
// [R15] Four scratch save registers for interrupt critical sections.
// [R16] Two-bit privilege field resets to zero, gates timer admin access.
// [R17] Same field selects level handling timer interrupts.
// [R18] Mask one blocks the interrupt, zero lets it through.
// [R19] Every defined mask bit resets to one.
// [R20] Simultaneous set and clear of a bit: set wins.
// [R21] Reserved bit writes do not change mask state.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "imscu_defines.vh"
module imscu_top #(
	parameter SRC_LOW_W = 32,
	parameter SRC_HIGH_W = 17
) (
	input wire i_mclk,
	input wire i_reset,
	input wire [`IMSCU_ADDR_W-1:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr_stb,
	input wire i_rd_stb,
	input wire [1:0] i_cur_priv,
	input wire [SRC_LOW_W-1:0] i_src_low,
	input wire [SRC_HIGH_W-1:0] i_src_high,
	output reg [31:0] o_rdata,
	output reg [SRC_LOW_W-1:0] o_pend_low,
	output reg [SRC_HIGH_W-1:0] o_pend_high,
	output reg [`IMSCU_PL_W-1:0] o_timer_int_level,
	output reg o_timer_admin_ok
);
	wire [31:0] mask_low;
	wire [31:0] mask_high;
	wire set_low_stb;
	wire set_high_stb;
	wire clr_low_stb;
	wire clr_high_stb;
	reg [31:0] save_reg [0:3];
	reg [`IMSCU_PL_W-1:0] timer_pl_reg;
	reg [31:0] rdata_next;
	integer k;

	localparam [31:0] LOW_VALID = `IMSCU_LOW_VALID;
	localparam [31:0] HIGH_VALID = `IMSCU_HIGH_VALID;

	// Strobe is an argument so the assigns follow it
	function wr_hit;
		input stb;
		input [`IMSCU_ADDR_W-1:0] addr;
		input [`IMSCU_ADDR_W-1:0] off;
		begin
			wr_hit = stb && (addr == off);
		end
	endfunction

	assign set_low_stb = wr_hit(i_wr_stb, i_addr, `IMSCU_OFF_SET_LOW); // see [R2]
	assign set_high_stb = wr_hit(i_wr_stb, i_addr, `IMSCU_OFF_SET_HIGH); // see [R3]
	assign clr_low_stb = wr_hit(i_wr_stb, i_addr, `IMSCU_OFF_CLR_LOW); // see [R4]
	assign clr_high_stb = wr_hit(i_wr_stb, i_addr, `IMSCU_OFF_CLR_HIGH); // see [R1]

	// Valid masks place every source at its position
	// see [R5] see [R6] see [R7] see [R8] see [R9] see [R10]
	imscu_mask_word #(
		.VALID(`IMSCU_LOW_VALID),
		.RESET_VAL(`IMSCU_LOW_RESET)
	) u_low (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_set_stb(set_low_stb),
		.i_clr_stb(clr_low_stb),
		.i_wdata(i_wdata),
		.o_mask(mask_low)
	);

	// see [R11] see [R12] see [R13] see [R14]
	imscu_mask_word #(
		.VALID(`IMSCU_HIGH_VALID),
		.RESET_VAL(`IMSCU_HIGH_RESET)
	) u_high (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_set_stb(set_high_stb),
		.i_clr_stb(clr_high_stb),
		.i_wdata(i_wdata),
		.o_mask(mask_high)
	);

	// Save and privilege registers
	always @(posedge i_mclk) begin
		if (i_reset) begin
			for (k = 0; k < 4; k = k + 1) begin
				save_reg[k] <= 32'h0000_0000;
			end
			timer_pl_reg <= `IMSCU_PL_RESET; // see [R16]
		end else if (i_wr_stb) begin
			if (i_addr == `IMSCU_OFF_SAVE0) begin
				save_reg[0] <= i_wdata; // see [R15]
			end else if (i_addr == `IMSCU_OFF_SAVE1) begin
				save_reg[1] <= i_wdata;
			end else if (i_addr == `IMSCU_OFF_SAVE2) begin
				save_reg[2] <= i_wdata;
			end else if (i_addr == `IMSCU_OFF_SAVE3) begin
				save_reg[3] <= i_wdata;
			end else if (i_addr == `IMSCU_OFF_TIMER_PL) begin
				timer_pl_reg <= i_wdata[`IMSCU_PL_W-1:0];
			end
		end
	end

	// Read mux; write-only and unmapped read zero
	always @* begin
		rdata_next = 32'h0000_0000;
		if (i_addr == `IMSCU_OFF_MASK_LOW) begin
			rdata_next = mask_low | `IMSCU_LOW_FIXED1;
		end else if (i_addr == `IMSCU_OFF_MASK_HIGH) begin
			rdata_next = mask_high;
		end else if (i_addr == `IMSCU_OFF_SAVE0) begin
			rdata_next = save_reg[0];
		end else if (i_addr == `IMSCU_OFF_SAVE1) begin
			rdata_next = save_reg[1];
		end else if (i_addr == `IMSCU_OFF_SAVE2) begin
			rdata_next = save_reg[2];
		end else if (i_addr == `IMSCU_OFF_SAVE3) begin
			rdata_next = save_reg[3];
		end else if (i_addr == `IMSCU_OFF_TIMER_PL) begin
			rdata_next = {{(32-`IMSCU_PL_W){1'b0}}, timer_pl_reg};
		end
	end

	always @(posedge i_mclk) begin
		if (i_reset) begin
			o_rdata <= 32'h0000_0000;
			o_pend_low <= {SRC_LOW_W{1'b0}};
			o_pend_high <= {SRC_HIGH_W{1'b0}};
			o_timer_int_level <= `IMSCU_PL_RESET;
			o_timer_admin_ok <= 1'b0;
		end else begin
			o_rdata <= i_rd_stb ? rdata_next : 32'h0000_0000;
			// Unmasked sources pass through
			o_pend_low <= i_src_low & ~mask_low[SRC_LOW_W-1:0]
				& LOW_VALID[SRC_LOW_W-1:0]; // see [R18]
			// Reserved high positions never pend
			o_pend_high <= i_src_high & ~mask_high[SRC_HIGH_W-1:0]
				& HIGH_VALID[SRC_HIGH_W-1:0]; // see [R18] see [R21]
			o_timer_int_level <= timer_pl_reg; // see [R17]
			o_timer_admin_ok <= (i_cur_priv >= timer_pl_reg); // see [R16]
		end
	end
endmodule // imscu_top

/* verif/imscu_chk.sv */
// Port checker for the interrupt mask unit
`timescale 1ns/1ps
`include "imscu_defines.vh"
module imscu_chk (
	input i_mclk,
	input i_reset,
	input [`IMSCU_ADDR_W-1:0] i_addr,
	input [31:0] i_wdata,
	input i_wr_stb,
	input [1:0] i_cur_priv,
	input [31:0] i_src_low,
	input [16:0] i_src_high,
	input [31:0] o_pend_low,
	input [16:0] o_pend_high,
	input [`IMSCU_PL_W-1:0] o_timer_int_level,
	input o_timer_admin_ok
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	chk_rst_quiet: assert property ($fell(i_reset) |->
		!o_pend_low && !o_pend_high) else $error("pend after reset");
	chk_pend_low: assert property (!(o_pend_low & ~$past(i_src_low)))
		else $error("low pend without source");
	chk_pend_high: assert property (!(o_pend_high & ~$past(i_src_high)))
		else $error("high pend without source");
	chk_rsv_low: assert property (!(o_pend_low & ~`IMSCU_LOW_VALID))
		else $error("reserved low bit pending");
	chk_rsv_high: assert property (o_pend_high[14:6] == 9'h000)
		else $error("reserved high bit pending");
	chk_clr_open: assert property (i_wr_stb &&
		i_addr == `IMSCU_OFF_CLR_LOW && i_wdata[1] ##1 i_src_low[1]
		|=> o_pend_low[1]) else $error("clear did not unmask");
	chk_set_block: assert property (i_wr_stb &&
		i_addr == `IMSCU_OFF_SET_HIGH && i_wdata[5] |-> ##2 !o_pend_high[5])
		else $error("set did not mask");
	chk_lvl_write: assert property (i_wr_stb &&
		i_addr == `IMSCU_OFF_TIMER_PL |-> ##2
		o_timer_int_level == $past(i_wdata[1:0], 2)) else $error("level");
	chk_admin_gate: assert property (!$past(i_reset) |->
		o_timer_admin_ok == ($past(i_cur_priv) >= o_timer_int_level))
		else $error("admin gate wrong");
	cover property (o_pend_low[25]);
	cover property (o_timer_admin_ok);
	cover property (o_pend_high[0]);
endmodule // imscu_chk
bind imscu_top imscu_chk chk_u (.*);

/* verif/imscu_src_model.sv */
// Interrupt source model for the raw request lines
`timescale 1ns/1ps
module imscu_src_model (
	input i_mclk,
	input [48:0] i_req,
	output reg [31:0] o_src_low,
	output reg [16:0] o_src_high
);
	always @(posedge i_mclk) begin
		{o_src_high, o_src_low} <= i_req;
	end
endmodule // imscu_src_model

/* verif/imscu_tb.sv */
// Self-checking bench for the interrupt mask unit
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
	miscompares++; $display("unexpected %0t %h not %h", $time, a, b); end end
module testbench;
	reg i_mclk = 0, i_reset = 1, i_wr_stb = 0, i_rd_stb = 0;
	reg [3:0] i_addr = 0;
	reg [31:0] i_wdata = 0;
	reg [1:0] i_cur_priv = 0;
	reg [48:0] req = 0;
	wire [31:0] i_src_low, o_rdata, o_pend_low;
	wire [16:0] i_src_high, o_pend_high;
	wire [1:0] o_timer_int_level;
	wire o_timer_admin_ok;
	integer miscompares = 0, check_count = 0, cyc = 0, i;
	always #25 i_mclk = ~i_mclk;
	imscu_src_model src_u (.i_mclk(i_mclk), .i_req(req),
		.o_src_low(i_src_low), .o_src_high(i_src_high));
	imscu_top dut_u (.*);
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge i_mclk);
			i_wr_stb <= 1;
			i_addr <= a;
			i_wdata <= d;
			@(posedge i_mclk);
			i_wr_stb <= 0;
		end
	endtask
	task rdc(input [3:0] a, input [31:0] e);
		begin
			@(posedge i_mclk);
			i_rd_stb <= 1;
			i_addr <= a;
			@(posedge i_mclk);
			i_rd_stb <= 0;
			#1 `CHK(o_rdata, e)
		end
	endtask
	task settle;
		begin
			repeat (2) @(posedge i_mclk);
			#1;
		end
	endtask
	task t_reset;
		begin
			rdc(4'h0, 32'hFFFC_0782);
			rdc(4'h1, 32'h0001_803F);
			rdc(4'hA, 32'h0000_0000);
			rdc(4'hF, 32'h0000_0000);
		end
	endtask
	task t_mask;
		begin
			@(posedge i_mclk);
			req <= {49{1'b1}};
			wr(4'h2, 32'hFFFF_FFFF);
			rdc(4'h0, 32'h0030_0000);
			wr(4'h3, 32'hFFFF_FFFF);
			settle;
			`CHK(o_pend_low, 32'hFFCC_0782)
			`CHK(o_pend_high, 17'h1_803F)
			wr(4'h4, 32'h0200_0000);
			wr(4'h5, 32'h0000_0021);
			wr(4'h0, 32'h0000_0000);
			settle;
			`CHK(o_pend_low, 32'hFDCC_0782)
			`CHK(o_pend_high, 17'h1_801E)
			rdc(4'h0, 32'h0230_0000);
		end
	endtask
	task t_save;
		begin
			for (i = 0; i < 4; i++)
				wr(4'(6 + i), 32'h5A5A_0000 + i);
			for (i = 0; i < 4; i++)
				rdc(4'(6 + i), 32'h5A5A_0000 + i);
		end
	endtask
	task t_priv;
		begin
			wr(4'hA, 32'hFFFF_FFFF);
			rdc(4'hA, 32'h0000_0003);
			@(posedge i_mclk);
			i_cur_priv <= 2'h2;
			settle;
			`CHK(o_timer_int_level, 2'h3)
			`CHK(o_timer_admin_ok, 1'b0)
			@(posedge i_mclk);
			i_cur_priv <= 2'h3;
			settle;
			`CHK(o_timer_admin_ok, 1'b1)
		end
	endtask
	// Reset again with sources active and masks open except low bit 25 and high bits 5 and 0
	task t_rerun;
		begin
			@(posedge i_mclk);
			i_reset <= 1;
			settle;
			`CHK(o_pend_low, 32'h0000_0000)
			@(posedge i_mclk);
			i_reset <= 0;
			rdc(4'h0, 32'hFFFC_0782);
			rdc(4'h1, 32'h0001_803F);
			rdc(4'h6, 32'h0000_0000);
			settle;
			`CHK(o_pend_low, 32'h0000_0000)
			`CHK(o_pend_high, 17'h0_0000)
			`CHK(o_timer_int_level, 2'h0)
			`CHK(o_timer_admin_ok, 1'b1)
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d miscompares %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_reset <= 0;
		t_reset;
		t_mask;
		t_save;
		t_priv;
		t_rerun;
		wrap_up;
	end
endmodule // testbench
